// >>> common/cise_pkg.sv
// Package with opcodes, widths and flag reset values for the instruction subset executor.
package cise_pkg;

  // Operation selected for the current instruction cycle.
  typedef enum logic [2:0] {
    CISE_OP_NONE,
    CISE_OP_WDT_CLEAR,
    CISE_OP_COMPARE,
    CISE_OP_DEC_ADJUST,
    CISE_OP_DEC_SKIP
  } cise_op_t;

  // Data and address widths.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0]  ADDR_MAX = 7'h7f;

  // Watchdog and prescaler clear value and widths.
  localparam int unsigned WDT_W      = 8;
  localparam int unsigned PRESCALE_W = 8;
  localparam logic [7:0]  CLEAR_VAL  = 8'h00;

  // Destination select encoding.
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;

  // Decimal adjust constants.
  localparam logic [3:0] BCD_LIMIT  = 4'h9;
  localparam logic [7:0] BCD_ADJ_LO = 8'h06;
  localparam logic [7:0] BCD_ADJ_HI = 8'h60;

  // Reset values of the flags and the accumulator.
  localparam logic       RST_FLAG_Z     = 1'b0;
  localparam logic       RST_FLAG_C     = 1'b0;
  localparam logic       RST_FLAG_DC    = 1'b0;
  localparam logic       RST_TO_N       = 1'b1;
  localparam logic       RST_PD_N       = 1'b1;
  localparam logic [7:0] RST_ACC        = 8'h00;

  // APB register byte offsets.
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ACC    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;

  // Command register field positions.
  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_DEST_BIT = 4;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CMD_RDAT_LSB = 16;

  // Status register field positions.
  localparam int unsigned ST_C_BIT    = 0;
  localparam int unsigned ST_DC_BIT   = 1;
  localparam int unsigned ST_Z_BIT    = 2;
  localparam int unsigned ST_PD_BIT   = 3;
  localparam int unsigned ST_TO_BIT   = 4;
  localparam int unsigned ST_BUSY_BIT = 8;
  localparam int unsigned ST_SKIP_BIT = 9;

  // Command opcode values written by software.
  localparam logic [3:0] CMDV_WDT_CLEAR  = 4'h1;
  localparam logic [3:0] CMDV_COMPARE    = 4'h2;
  localparam logic [3:0] CMDV_DEC_ADJUST = 4'h3;
  localparam logic [3:0] CMDV_DEC_SKIP   = 4'h4;

endpackage : cise_pkg

// >>> design/cise_alu.sv
// Combinational datapath computing results and flags for the instruction subset.
`timescale 1ns/1ps
module cise_alu (
  // Operation and operands.
  input  wire cise_pkg::cise_op_t i_op,
  input  wire logic [7:0]         i_acc,
  input  wire logic [7:0]         i_reg_data,
  input  wire logic               i_carry,
  input  wire logic               i_dcarry,
  // Results.
  output logic [7:0]              o_result,
  output logic                    o_carry,
  output logic                    o_zero
);

  logic [8:0] diff;
  logic [7:0] adj;
  logic       lo_fix;
  logic       hi_fix;

  // Compare and decrement arithmetic plus packed decimal correction.
  always_comb begin
    diff     = {1'b0, i_reg_data} - {1'b0, i_acc};
    lo_fix   = (i_acc[3:0] > cise_pkg::BCD_LIMIT) || i_dcarry;
    hi_fix   = (i_acc > 8'h99) || i_carry;
    adj      = i_acc;
    o_result = i_acc;
    o_carry  = i_carry;
    o_zero   = 1'b0;
    unique case (i_op)
      cise_pkg::CISE_OP_COMPARE: begin
        o_result = diff[7:0];
        o_carry  = ~diff[8];
        o_zero   = (diff[7:0] == 8'h00);
      end
      cise_pkg::CISE_OP_DEC_ADJUST: begin
        if (lo_fix) begin
          adj = adj + cise_pkg::BCD_ADJ_LO;
        end
        if (hi_fix) begin
          adj = adj + cise_pkg::BCD_ADJ_HI;
        end
        o_result = adj;
        o_carry  = hi_fix;
        o_zero   = (adj == 8'h00);
      end
      cise_pkg::CISE_OP_DEC_SKIP: begin
        o_result = i_reg_data - 8'h01;
        o_zero   = (i_reg_data == 8'h01);
      end
      default: begin
        o_result = i_acc;
      end
    endcase
  end

endmodule : cise_alu

// >>> design/cise_exec.sv
// Executor for watchdog clear, compare, decimal adjust and decrement skip.
// Operation
// - watchdog clear zeroes the watchdog counter.
// - also zeroes prescaler when assigned to watchdog.
// - sets timeout and powerdown flags, one cycle.
// - compare subtracts accumulator, only Z and C.
// - decimal adjust writes accumulator, only carry.
// - decrement result to accumulator or register.
// - zero result discards fetched next instruction.
// - one cycle, or two when skipping.
`timescale 1ns/1ps
module cise_exec (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Prescaler assignment from the timer block.
  input  wire logic        i_prescaler_to_wdt,
  // Core side effects.
  output logic             o_wdt_clear,
  output logic             o_prescaler_clear,
  output logic             o_reg_we,
  output logic [6:0]       o_reg_addr,
  output logic [7:0]       o_reg_wdata,
  output logic             o_discard_next,
  output logic             o_busy
);

  typedef enum logic [1:0] {
    CISE_ST_IDLE,
    CISE_ST_EXEC,
    CISE_ST_SKIP
  } cise_state_t;

  cise_state_t        state;
  cise_state_t        next_state;
  cise_pkg::cise_op_t op;
  cise_pkg::cise_op_t next_op;
  logic [7:0]         acc;
  logic [7:0]         next_acc;
  logic               flag_c;
  logic               next_flag_c;
  logic               flag_dc;
  logic               flag_z;
  logic               next_flag_z;
  logic               timeout_flag_n;
  logic               next_timeout_flag_n;
  logic               powerdown_flag_n;
  logic               next_powerdown_flag_n;
  logic               dest;
  logic               next_dest;
  logic [6:0]         addr;
  logic [6:0]         next_addr;
  logic [7:0]         rdat;
  logic [7:0]         next_rdat;
  logic [7:0]         result;
  logic [7:0]         next_result;
  logic               next_skip;
  logic               skip;
  logic [7:0]         alu_result;
  logic               alu_carry;
  logic               alu_zero;
  logic               wr_en;
  logic               rd_en;
  logic               addr_ok;
  cise_pkg::cise_op_t cmd_op;
  logic               wdt_clr;
  logic               pre_clr;
  logic               next_wdt_clr;
  logic               next_pre_clr;
  logic               reg_we;
  logic               next_reg_we;
  logic [31:0]        next_prdata;

  // Datapath for the selected operation.
  cise_alu u_alu (
    .i_op       (op),
    .i_acc      (acc),
    .i_reg_data (rdat),
    .i_carry    (flag_c),
    .i_dcarry   (flag_dc),
    .o_result   (alu_result),
    .o_carry    (alu_carry),
    .o_zero     (alu_zero)
  );

  // Bus decode; the slave always answers in the first access cycle.
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign addr_ok = (paddr == cise_pkg::REG_CMD) || (paddr == cise_pkg::REG_ACC)
                || (paddr == cise_pkg::REG_STATUS) || (paddr == cise_pkg::REG_RESULT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!addr_ok || (wr_en && paddr == cise_pkg::REG_CMD && o_busy));
  assign o_busy  = (state != CISE_ST_IDLE);
  assign flag_dc = cise_pkg::RST_FLAG_DC;

  // Decode of the command opcode field.
  always_comb begin
    unique case (pwdata[cise_pkg::CMD_OP_LSB +: 4])
      cise_pkg::CMDV_WDT_CLEAR:  cmd_op = cise_pkg::CISE_OP_WDT_CLEAR;
      cise_pkg::CMDV_COMPARE:    cmd_op = cise_pkg::CISE_OP_COMPARE;
      cise_pkg::CMDV_DEC_ADJUST: cmd_op = cise_pkg::CISE_OP_DEC_ADJUST;
      cise_pkg::CMDV_DEC_SKIP:   cmd_op = cise_pkg::CISE_OP_DEC_SKIP;
      default:                   cmd_op = cise_pkg::CISE_OP_NONE;
    endcase
  end

  // Next-state logic for sequencing, flags and accumulator.
  always_comb begin
    next_state            = state;
    next_op               = op;
    next_acc              = acc;
    next_flag_c           = flag_c;
    next_flag_z           = flag_z;
    next_timeout_flag_n   = timeout_flag_n;
    next_powerdown_flag_n = powerdown_flag_n;
    next_dest             = dest;
    next_addr             = addr;
    next_rdat             = rdat;
    next_result           = result;
    next_skip             = 1'b0;
    next_wdt_clr          = 1'b0;
    next_pre_clr          = 1'b0;
    next_reg_we           = 1'b0;
    unique case (state)
      CISE_ST_IDLE: begin
        if (wr_en && paddr == cise_pkg::REG_CMD && cmd_op != cise_pkg::CISE_OP_NONE) begin
          next_op    = cmd_op;
          next_dest  = pwdata[cise_pkg::CMD_DEST_BIT];
          next_addr  = pwdata[cise_pkg::CMD_ADDR_LSB +: cise_pkg::ADDR_W];
          next_rdat  = pwdata[cise_pkg::CMD_RDAT_LSB +: cise_pkg::DATA_W];
          next_state = CISE_ST_EXEC;
        end else if (wr_en && paddr == cise_pkg::REG_ACC) begin
          next_acc = pwdata[7:0];
        end
      end
      CISE_ST_EXEC: begin
        next_state  = CISE_ST_IDLE;
        next_result = alu_result; // Last datapath result, also the write-back value.
        unique case (op)
          cise_pkg::CISE_OP_WDT_CLEAR: begin
            next_wdt_clr = 1'b1;
            next_pre_clr = i_prescaler_to_wdt;
            next_timeout_flag_n   = 1'b1;
            next_powerdown_flag_n = 1'b1;
          end
          cise_pkg::CISE_OP_COMPARE: begin
            next_flag_c = alu_carry;
            next_flag_z = alu_zero;
          end
          cise_pkg::CISE_OP_DEC_ADJUST: begin
            next_acc    = alu_result;
            next_flag_c = alu_carry;
          end
          cise_pkg::CISE_OP_DEC_SKIP: begin
            if (dest == cise_pkg::DEST_ACC) begin
              next_acc = alu_result;
            end else begin
              next_reg_we = 1'b1;
            end
            if (alu_zero) begin
              next_skip  = 1'b1;
              next_state = CISE_ST_SKIP;
            end
          end
          default: begin
            next_state = CISE_ST_IDLE;
          end
        endcase
      end
      CISE_ST_SKIP: begin
        next_state = CISE_ST_IDLE;
      end
      default: begin
        next_state = CISE_ST_IDLE;
      end
    endcase
  end

  // Sequencer and architectural state registers.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state            <= CISE_ST_IDLE;
      op               <= cise_pkg::CISE_OP_NONE;
      acc              <= cise_pkg::RST_ACC;
      flag_c           <= cise_pkg::RST_FLAG_C;
      flag_z           <= cise_pkg::RST_FLAG_Z;
      timeout_flag_n   <= cise_pkg::RST_TO_N;
      powerdown_flag_n <= cise_pkg::RST_PD_N;
      dest             <= cise_pkg::DEST_ACC;
      addr             <= 7'h00;
      rdat             <= 8'h00;
      skip             <= 1'b0;
      wdt_clr          <= 1'b0;
      pre_clr          <= 1'b0;
      reg_we           <= 1'b0;
      result           <= 8'h00;
    end else begin
      state            <= next_state;
      op               <= next_op;
      acc              <= next_acc;
      flag_c           <= next_flag_c;
      flag_z           <= next_flag_z;
      timeout_flag_n   <= next_timeout_flag_n;
      powerdown_flag_n <= next_powerdown_flag_n;
      dest             <= next_dest;
      addr             <= next_addr;
      rdat             <= next_rdat;
      skip             <= next_skip;
      wdt_clr          <= next_wdt_clr;
      pre_clr          <= next_pre_clr;
      reg_we           <= next_reg_we;
      result           <= next_result;
    end
  end

  // Registered side-effect outputs.
  assign o_wdt_clear       = wdt_clr;
  assign o_prescaler_clear = pre_clr;
  assign o_discard_next    = skip;
  assign o_reg_we          = reg_we;
  assign o_reg_addr        = addr;
  assign o_reg_wdata       = result;

  // Read data mux.
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        cise_pkg::REG_ACC:    next_prdata[7:0] = acc;
        cise_pkg::REG_RESULT: next_prdata[7:0] = result;
        cise_pkg::REG_STATUS: begin
          next_prdata[cise_pkg::ST_C_BIT]    = flag_c;
          next_prdata[cise_pkg::ST_DC_BIT]   = flag_dc;
          next_prdata[cise_pkg::ST_Z_BIT]    = flag_z;
          next_prdata[cise_pkg::ST_PD_BIT]   = powerdown_flag_n;
          next_prdata[cise_pkg::ST_TO_BIT]   = timeout_flag_n;
          next_prdata[cise_pkg::ST_BUSY_BIT] = o_busy;
          next_prdata[cise_pkg::ST_SKIP_BIT] = skip;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end
  assign prdata = next_prdata;

  // watchdog clear pulse follows the command.
  a_wdt_clear_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state == CISE_ST_EXEC && op == cise_pkg::CISE_OP_WDT_CLEAR) |=> o_wdt_clear)
    else $error("watchdog clear pulse missing");

  a_prescale_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_prescaler_clear |-> (o_wdt_clear && $past(i_prescaler_to_wdt)))
    else $error("prescaler cleared while not assigned");

  a_wdt_flags_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_wdt_clear |-> (timeout_flag_n && powerdown_flag_n && !o_busy))
    else $error("watchdog clear flags wrong");

  a_cmp_keep_acc: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state == CISE_ST_EXEC && op == cise_pkg::CISE_OP_COMPARE) |=> (acc == $past(acc)) && !o_reg_we)
    else $error("compare changed accumulator");

  a_cmp_carry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state == CISE_ST_EXEC && op == cise_pkg::CISE_OP_COMPARE)
      |=> (flag_c == ($past(rdat) >= $past(acc))) && (flag_z == ($past(rdat) == $past(acc))))
    else $error("compare flags wrong");

  a_adj_keep_z: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state == CISE_ST_EXEC && op == cise_pkg::CISE_OP_DEC_ADJUST) |=> $stable(flag_z))
    else $error("adjust changed zero flag");

  a_dec_dest_reg: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state == CISE_ST_EXEC && op == cise_pkg::CISE_OP_DEC_SKIP && dest)
      |=> o_reg_we && (o_reg_wdata == $past(rdat) - 8'h01))
    else $error("decrement writeback wrong");

  a_skip_on_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state == CISE_ST_EXEC && op == cise_pkg::CISE_OP_DEC_SKIP)
      |=> (o_discard_next == ($past(rdat) == 8'h01)))
    else $error("skip decision wrong");

  a_skip_length: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_discard_next |-> o_busy ##1 !o_busy)
    else $error("skip length wrong");

  // Main scenarios.
  c_wdt_clear: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_prescaler_clear);
  c_skip:      cover property (@(posedge i_clk) disable iff (!i_rst_b) o_discard_next);
  c_cmp_eq:    cover property (@(posedge i_clk) disable iff (!i_rst_b)
    state == CISE_ST_EXEC && op == cise_pkg::CISE_OP_COMPARE && alu_zero);
  c_adj_carry: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    state == CISE_ST_EXEC && op == cise_pkg::CISE_OP_DEC_ADJUST && alu_carry);

endmodule : cise_exec

// >>> dv/cise_exec_test.sv
// Self-checking testbench for the instruction subset executor.
`timescale 1ns/1ps
module cise_exec_test;
  logic        i_clk;
  logic        i_rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        i_prescaler_to_wdt;
  logic        o_wdt_clear;
  logic        o_prescaler_clear;
  logic        o_reg_we;
  logic [6:0]  o_reg_addr;
  logic [7:0]  o_reg_wdata;
  logic        o_discard_next;
  logic        o_busy;
  int          n_fail;
  int          n_compared;
  int          n_busy;
  logic        saw_wdt, saw_pre, saw_we, saw_disc;
  logic [6:0]  we_addr;
  logic [7:0]  we_data;
  logic [31:0] rd;
  logic        err;

  cise_exec cise_exec_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_prescaler_to_wdt(i_prescaler_to_wdt), .o_wdt_clear(o_wdt_clear),
    .o_prescaler_clear(o_prescaler_clear), .o_reg_we(o_reg_we), .o_reg_addr(o_reg_addr),
    .o_reg_wdata(o_reg_wdata), .o_discard_next(o_discard_next), .o_busy(o_busy)
  );

  // Clock of 8 ns period.
  always #4 i_clk = ~i_clk;

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // One APB transfer; starts right after a rising edge, keeps psel up when hold is set.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic hold, output logic [31:0] r, output logic e);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0000_0001, 32'h0000_0000, "pready timeout");
    r = prdata;
    e = pslverr;
    penable <= 1'b0;
    // Without hold, an idle cycle follows so the next call never reassigns psel at once.
    if (!hold) begin
      psel <= 1'b0;
      @(posedge i_clk);
    end
  endtask : apb

  // Issues one instruction and records busy length and side-effect pulses.
  task automatic run_op(input logic [3:0] op, input logic dest, input logic [6:0] ra,
                        input logic [7:0] rv);
    apb(1'b1, cise_pkg::REG_CMD, {8'h00, rv, 1'b0, ra, 3'b000, dest, op}, 1'b1, rd, err);
    psel <= 1'b0;
    chk(err, 1'b0, "command refused");
    n_busy = 0;
    saw_wdt = 0;
    saw_pre = 0;
    saw_we = 0;
    saw_disc = 0;
    // Outputs are sampled at the falling edge, where they have settled.
    repeat (5) begin
      @(negedge i_clk);
      if (o_busy === 1'b1) n_busy++;
      if (o_wdt_clear === 1'b1) saw_wdt = 1;
      if (o_prescaler_clear === 1'b1) saw_pre = 1;
      if (o_discard_next === 1'b1) saw_disc = 1;
      if (o_reg_we === 1'b1) begin
        saw_we = 1;
        we_addr = o_reg_addr;
        we_data = o_reg_wdata;
      end
    end
    // Hand back at a rising edge so the next request starts there.
    @(posedge i_clk);
  endtask : run_op

  // Accumulator write and register read helpers.
  task automatic set_acc(input logic [7:0] v);
    apb(1'b1, cise_pkg::REG_ACC, {24'h00_0000, v}, 1'b0, rd, err);
  endtask : set_acc

  task automatic rd_reg(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000, 1'b0, rd, err);
  endtask : rd_reg

  // Reset values of accumulator and status.
  task automatic t_reset();
    rd_reg(cise_pkg::REG_STATUS);
    chk(rd, 32'h0000_0018, "status after reset");
    rd_reg(cise_pkg::REG_ACC);
    chk(rd[7:0], cise_pkg::RST_ACC, "acc after reset");
    $display("test reset done");
  endtask : t_reset

  // Watchdog clear with the prescaler assigned and then not assigned.
  task automatic t_wdt();
    i_prescaler_to_wdt <= 1'b1;
    run_op(cise_pkg::CMDV_WDT_CLEAR, 1'b0, 7'h00, 8'h00);
    chk(saw_wdt, 1'b1, "watchdog clear pulse");
    chk(saw_pre, 1'b1, "prescaler clear when assigned");
    chk(n_busy, 1, "watchdog clear cycles");
    i_prescaler_to_wdt <= 1'b0;
    run_op(cise_pkg::CMDV_WDT_CLEAR, 1'b0, 7'h00, 8'h00);
    chk(saw_pre, 1'b0, "prescaler kept when not assigned");
    rd_reg(cise_pkg::REG_STATUS);
    chk(rd[4:3], 2'b11, "timeout and powerdown flags");
    $display("test watchdog done");
  endtask : t_wdt

  // Compare above, equal and below the accumulator.
  task automatic t_compare();
    logic [7:0] rv [3];
    rv = '{8'h34, 8'h0c, 8'h05};
    set_acc(8'h0c);
    foreach (rv[k]) begin
      run_op(cise_pkg::CMDV_COMPARE, 1'b1, 7'h7f, rv[k]);
      chk(saw_we, 1'b0, "compare writes no register");
      rd_reg(cise_pkg::REG_STATUS);
      chk(rd[0], rv[k] >= 8'h0c, "compare carry");
      chk(rd[2], rv[k] == 8'h0c, "compare zero");
      chk(rd[4:3], 2'b11, "compare leaves other flags");
      rd_reg(cise_pkg::REG_ACC);
      chk(rd[7:0], 8'h0c, "compare keeps acc");
    end
    $display("test compare done");
  endtask : t_compare

  // Decimal adjust without and with upper digit overflow; carry is clear on entry.
  task automatic t_adjust();
    logic [7:0] a_in [2];
    logic [7:0] a_out [2];
    a_in = '{8'h4d, 8'h9a};
    a_out = '{8'h53, 8'h00};
    foreach (a_in[k]) begin
      // The loaded sum stands in for the addition, with nothing in between.
      set_acc(a_in[k]);
      run_op(cise_pkg::CMDV_DEC_ADJUST, 1'b0, 7'h00, 8'h00);
      rd_reg(cise_pkg::REG_ACC);
      chk(rd[7:0], a_out[k], "adjusted acc");
      rd_reg(cise_pkg::REG_STATUS);
      chk(rd[0], k == 1, "adjust carry");
      chk(rd[2], 1'b0, "adjust leaves zero flag");
    end
    $display("test adjust done");
  endtask : t_adjust

  // Decrement with and without skip, to both destinations.
  task automatic t_skip();
    set_acc(8'h11);
    run_op(cise_pkg::CMDV_DEC_SKIP, cise_pkg::DEST_ACC, 7'h10, 8'h05);
    chk(saw_we, 1'b0, "no register write to acc dest");
    chk(saw_disc, 1'b0, "no discard on nonzero");
    chk(n_busy, 1, "one cycle without skip");
    rd_reg(cise_pkg::REG_ACC);
    chk(rd[7:0], 8'h04, "decrement to acc");
    rd_reg(cise_pkg::REG_RESULT);
    chk(rd[7:0], 8'h04, "result register");
    run_op(cise_pkg::CMDV_DEC_SKIP, cise_pkg::DEST_REG, 7'h7f, 8'h01);
    chk({saw_we, we_addr, we_data}, {1'b1, 7'h7f, 8'h00}, "decrement to reg");
    chk(saw_disc, 1'b1, "discard on zero");
    chk(n_busy, 2, "two cycles with skip");
    rd_reg(cise_pkg::REG_ACC);
    chk(rd[7:0], 8'h04, "acc kept for reg dest");
    run_op(cise_pkg::CMDV_DEC_SKIP, cise_pkg::DEST_ACC, 7'h00, 8'h01);
    chk(saw_disc, 1'b1, "discard on zero to acc");
    rd_reg(cise_pkg::REG_ACC);
    chk(rd[7:0], 8'h00, "zero result in acc");
    $display("test skip done");
  endtask : t_skip

  // Unmapped access and a command while a skip is still executing.
  task automatic t_errors();
    rd_reg(8'h10);
    chk(err, 1'b1, "unmapped address error");
    apb(1'b1, cise_pkg::REG_CMD, 32'h0001_0104, 1'b1, rd, err);
    apb(1'b1, cise_pkg::REG_CMD, 32'h0000_0001, 1'b0, rd, err);
    chk(err, 1'b1, "command while busy refused");
    repeat (4) @(posedge i_clk);
    // An unknown opcode is ignored and starts no instruction.
    run_op(4'h0, 1'b0, 7'h00, 8'h00);
    chk(n_busy, 0, "unknown opcode ignored");
    chk(saw_wdt, 1'b0, "unknown opcode no watchdog clear");
    $display("test errors done");
  endtask : t_errors

  // Watchdog against a hang.
  initial begin
    #40000;
    n_fail++;
    close_out();
  end

  // Main sequence.
  initial begin
    i_clk = 1'b0;
    i_rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    i_prescaler_to_wdt = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_wdt();
    t_compare();
    t_adjust();
    t_skip();
    t_errors();
    close_out();
  end
endmodule : cise_exec_test
